// File: rtl/pidr_pkg.sv
`default_nettype none
package pidr_pkg;
  // normalized signals are unsigned, 1.0 is 2**16
  localparam int NW = 17;
  localparam logic [16:0] ONE = 17'h10000;
  localparam logic [16:0] HALF = 17'h08000;
  // gain is unsigned fixed point with 15 fraction bits
  localparam int GFRAC = 15;
  localparam int NINST = 2;
  localparam int SELW = 4;
  // time settings are whole milliseconds
  localparam int TW = 27;
  localparam int DTW = 14;
  localparam int DIVW = 48;
  // time base
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  // bus decode: one 32-byte slot per regulator
  localparam int SLOT_BIT = 5;
  localparam logic [2:0] R_CTRL = 3'h0;
  localparam logic [2:0] R_MAN = 3'h1;
  localparam logic [2:0] R_GAIN = 3'h2;
  localparam logic [2:0] R_TI = 3'h3;
  localparam logic [2:0] R_TD = 3'h4;
  localparam logic [2:0] R_DT = 3'h5;
  localparam logic [2:0] R_STAT = 3'h6;
  localparam logic [2:0] R_INTEG = 3'h7;
  // control word fields
  localparam int CB_INV_SP = 0;
  localparam int CB_INV_FB = 1;
  localparam int CB_INV_RST = 2;
  localparam int CB_MAN = 3;
  localparam int SEL_SP_LSB = 8;
  localparam int SEL_FB_LSB = 12;
  localparam int SEL_RST_LSB = 16;
  // status word fields, output value sits in the low bits
  localparam int ST_WIND = 24;
  localparam int ST_RST = 25;
  localparam int ST_MAN = 26;
  // setting limits
  localparam logic [31:0] GAIN_MAX = 32'hc3500000;
  localparam logic [31:0] T_MAX = 32'h05f5e100;
  localparam logic [31:0] DT_MIN = 32'h00000001;
  localparam logic [31:0] DT_MAX = 32'h00002710;
  localparam logic signed [47:0] INTEG_MAX = 48'sh00ffffffffff;

  typedef struct packed {
    logic inv_sp;
    logic inv_fb;
    logic inv_rst;
    logic manual;
    logic [SELW-1:0] sel_sp;
    logic [SELW-1:0] sel_fb;
    logic [SELW-1:0] sel_rst;
    logic [NW-1:0] man_val;
    logic [31:0] gain;
    logic [TW-1:0] ti;
    logic [TW-1:0] td;
    logic [DTW-1:0] dt;
  } pidr_cfg_type;

  // defaults: manual 0.5, gain 1.0, ti 100 ms, td 10 ms, dt 1 ms
  localparam pidr_cfg_type CFG_RST = '{
    inv_sp: 1'b0, inv_fb: 1'b0, inv_rst: 1'b0, manual: 1'b0,
    sel_sp: 4'h0, sel_fb: 4'h0, sel_rst: 4'h0,
    man_val: 17'h08000, gain: 32'h00008000,
    ti: 27'h0000064, td: 27'h000000a, dt: 14'h0001};

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_DIVI = 5'h02,
    S_DIVD = 5'h04,
    S_MATH = 5'h08,
    S_UPD = 5'h10
  } pidr_state_type;
endpackage
`default_nettype wire

// File: rtl/pidr_div.sv
`timescale 1ns/1ns
`default_nettype none
module pidr_div #(
  parameter int NUMW = 48,
  parameter int DENW = 27
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [NUMW-1:0] num,
  input wire logic [DENW-1:0] den,
  output logic [NUMW-1:0] quo,
  output logic done
);
  localparam int CW = $clog2(NUMW + 1);

  if (NUMW < 2 || DENW < 1) begin : g_bad
    $error("pidr_div: widths too small");
  end

  logic [NUMW-1:0] q_reg;
  logic [DENW:0] rem_reg;
  logic [DENW-1:0] d_reg;
  logic [CW-1:0] cnt_reg;
  logic busy_reg;
  logic done_reg;
  logic [DENW:0] trial;
  logic fits;

  // restoring division, one quotient bit per clock
  assign trial = {rem_reg[DENW-1:0], q_reg[NUMW-1]};
  assign fits = trial >= {1'b0, d_reg};

  always_ff @(posedge clk) begin
    if (rst) begin
      q_reg <= '0;
      rem_reg <= '0;
      d_reg <= '0;
    end else if (start) begin
      q_reg <= num;
      rem_reg <= '0;
      d_reg <= den;
    end else if (busy_reg) begin
      rem_reg <= fits ? trial - {1'b0, d_reg} : trial;
      q_reg <= {q_reg[NUMW-2:0], fits};
    end
  end

  // sequencing and the completion pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      done_reg <= 1'b0;
      if (start) begin
        busy_reg <= 1'b1;
        cnt_reg <= CW'(NUMW);
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - CW'(1);
        if (cnt_reg == CW'(1)) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end

  assign quo = q_reg;
  assign done = done_reg;
endmodule
`default_nettype wire

// File: rtl/pidr_top.sv
`timescale 1ns/1ns
`default_nettype none
module pidr_top
  import pidr_pkg::*;
#(
  parameter int NSRC = 8,
  parameter int MS_CYCLES = MS_NS / CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NSRC-1:0][NW-1:0] src_val,
  output logic [NINST-1:0][NW-1:0] ctrl_out,
  output logic [NINST-1:0] cycle_done
);

  if (NSRC < 1 || NSRC > 15 || MS_CYCLES < 2) begin : g_bad
    $error("pidr_top: NSRC or MS_CYCLES out of range");
  end

  // picks a source; 0 means unconnected and reads as zero
  function automatic logic [NW-1:0] pick(
    input logic [NSRC-1:0][NW-1:0] s,
    input logic [SELW-1:0] sel,
    input logic inv
  );
    logic [NW-1:0] v;
    v = '0;
    if (sel != '0 && 32'(sel) <= NSRC) begin
      v = s[sel - 4'h1];
      if (v > ONE) begin
        v = ONE;
      end
      if (inv) begin
        v = ONE - v;
      end
    end
    return v;
  endfunction

  // byte lane merge of a write into the current word
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // out-of-range settings are pinned to the nearest limit
  function automatic logic [31:0] clampu(
    input logic [31:0] v,
    input logic [31:0] lo,
    input logic [31:0] hi
  );
    logic [31:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // magnitude of a signed error or rate
  function automatic logic [NW-1:0] mag(input logic signed [17:0] x);
    logic [17:0] a;
    a = x[17] ? 18'(-x) : 18'(x);
    return a[NW-1:0];
  endfunction

  // integrator add that saturates instead of wrapping
  function automatic logic signed [47:0] sadd(
    input logic signed [47:0] a,
    input logic signed [47:0] b
  );
    logic signed [48:0] s;
    logic signed [47:0] r;
    s = 49'(a) + 49'(b);
    r = s[47:0];
    if (s > 49'(INTEG_MAX)) begin
      r = INTEG_MAX;
    end else if (s < -49'(INTEG_MAX)) begin
      r = -INTEG_MAX;
    end
    return r;
  endfunction

  pidr_cfg_type cfg_reg [NINST];
  logic [NINST-1:0][NW-1:0] out_arr;
  logic [NINST-1:0] wind_arr;
  logic [NINST-1:0] rsta_arr;
  logic signed [47:0] integ_arr [NINST];
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic [31:0] rmux;
  logic [31:0] wv;
  logic req;
  logic wr;
  logic hit;
  logic inst;
  logic [2:0] ridx;
  logic [31:0] ms_cnt_reg;
  logic ms_tick;

  // shared millisecond enable for all control cycle timers
  always_ff @(posedge clk) begin
    if (rst || ms_tick) begin
      ms_cnt_reg <= '0;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 32'h1;
    end
  end
  assign ms_tick = ms_cnt_reg == 32'(MS_CYCLES - 1);

  // bus decode; ack_reg in req stops a held request acting twice
  assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr = req & wb_we_i;
  assign hit = wb_adr_i[7:SLOT_BIT+1] == '0;
  assign inst = wb_adr_i[SLOT_BIT];
  assign ridx = wb_adr_i[4:2];

  // current content of the addressed register
  always_comb begin
    rmux = 32'h0;
    if (hit) begin
      case (ridx)
        R_CTRL: begin
          rmux[CB_INV_SP] = cfg_reg[inst].inv_sp;
          rmux[CB_INV_FB] = cfg_reg[inst].inv_fb;
          rmux[CB_INV_RST] = cfg_reg[inst].inv_rst;
          rmux[CB_MAN] = cfg_reg[inst].manual;
          rmux[SEL_SP_LSB +: SELW] = cfg_reg[inst].sel_sp;
          rmux[SEL_FB_LSB +: SELW] = cfg_reg[inst].sel_fb;
          rmux[SEL_RST_LSB +: SELW] = cfg_reg[inst].sel_rst;
        end
        R_MAN: rmux = 32'(cfg_reg[inst].man_val);
        R_GAIN: rmux = cfg_reg[inst].gain;
        R_TI: rmux = 32'(cfg_reg[inst].ti);
        R_TD: rmux = 32'(cfg_reg[inst].td);
        R_DT: rmux = 32'(cfg_reg[inst].dt);
        R_STAT: begin
          rmux[NW-1:0] = out_arr[inst];
          rmux[ST_WIND] = wind_arr[inst];
          rmux[ST_RST] = rsta_arr[inst];
          rmux[ST_MAN] = cfg_reg[inst].manual;
        end
        R_INTEG: rmux = integ_arr[inst][31:0];
        default: rmux = 32'h0;
      endcase
    end
  end

  assign wv = merge(rmux, wb_dat_i, wb_sel_i);

  // settings; writes to unmapped or status words are dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < NINST; k++) begin
        cfg_reg[k] <= CFG_RST;
      end
    end else if (wr && hit) begin
      case (ridx)
        R_CTRL: begin
          cfg_reg[inst].inv_sp <= wv[CB_INV_SP];
          cfg_reg[inst].inv_fb <= wv[CB_INV_FB];
          cfg_reg[inst].inv_rst <= wv[CB_INV_RST];
          cfg_reg[inst].manual <= wv[CB_MAN];
          cfg_reg[inst].sel_sp <= wv[SEL_SP_LSB +: SELW];
          cfg_reg[inst].sel_fb <= wv[SEL_FB_LSB +: SELW];
          cfg_reg[inst].sel_rst <= wv[SEL_RST_LSB +: SELW];
        end
        R_MAN: cfg_reg[inst].man_val <=
          NW'(clampu(wv, 32'h0, 32'(ONE)));
        R_GAIN: cfg_reg[inst].gain <= clampu(wv, 32'h0, GAIN_MAX);
        R_TI: cfg_reg[inst].ti <= TW'(clampu(wv, 32'h0, T_MAX));
        R_TD: cfg_reg[inst].td <= TW'(clampu(wv, 32'h0, T_MAX));
        R_DT: cfg_reg[inst].dt <= DTW'(clampu(wv, DT_MIN, DT_MAX));
        default: ;
      endcase
    end
  end

  // one wait state; ack drops the cycle after it was given
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      ack_reg <= req;
      if (req) begin
        rdat_reg <= wb_we_i ? 32'h0 : rmux;
      end
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  for (genvar g = 0; g < NINST; g++) begin : g_pid
    pidr_cfg_type c;
    pidr_state_type st_reg;
    logic [NW-1:0] sp;
    logic [NW-1:0] pv;
    logic [NW-1:0] rn;
    logic rst_act;
    logic run;
    logic go;
    logic div_start;
    logic div_done;
    logic [DTW-1:0] ms_reg;
    logic signed [17:0] e_now;
    logic signed [17:0] e_reg;
    logic signed [17:0] dpv_reg;
    logic [NW-1:0] pvprev_reg;
    logic signed [47:0] inc_reg;
    logic signed [47:0] d_reg;
    logic signed [47:0] sum_reg;
    logic signed [47:0] integ_reg;
    logic [DIVW-1:0] num;
    logic [DIVW-1:0] quo;
    logic [TW-1:0] den;
    logic signed [80:0] prod;
    logic ylt0;
    logic ygt1;
    logic wind;
    logic [NW-1:0] clip;
    logic [NW-1:0] out_reg;
    logic wind_reg;
    logic done_reg;

    assign c = cfg_reg[g];
    assign sp = pick(src_val, c.sel_sp, c.inv_sp);
    assign pv = pick(src_val, c.sel_fb, c.inv_fb);
    assign rn = pick(src_val, c.sel_rst, c.inv_rst);
    assign rst_act = rn >= HALF;
    assign e_now = $signed({1'b0, sp}) - $signed({1'b0, pv});

    always_ff @(posedge clk) begin
      if (rst || go) begin
        ms_reg <= '0;
      end else if (ms_tick) begin
        ms_reg <= ms_reg + DTW'(1);
      end
    end
    assign go = ms_tick && (ms_reg + DTW'(1) >= c.dt);
    assign run = go && st_reg == S_IDLE && !c.manual && !rst_act;

    // divider feeds: e*dt/ti first, then |dpv|*td/dt
    always_comb begin
      if (st_reg == S_IDLE) begin
        // zero ti yields no increment; the divider divides zero by one
        num = (c.ti == '0) ? '0 : DIVW'(mag(e_now)) * DIVW'(c.dt);
        den = (c.ti == '0) ? TW'(1) : c.ti;
      end else begin
        num = DIVW'(mag(dpv_reg)) * DIVW'(c.td);
        den = TW'(c.dt);
      end
    end
    assign div_start = run || (st_reg == S_DIVI && div_done);

    pidr_div #(.NUMW(DIVW), .DENW(TW)) u_div (
      .clk(clk),
      .rst(rst),
      .start(div_start),
      .num(num),
      .den(den),
      .quo(quo),
      .done(div_done)
    );

    // sequence of one control cycle
    always_ff @(posedge clk) begin
      if (rst) begin
        st_reg <= S_IDLE;
      end else begin
        case (st_reg)
          S_IDLE: st_reg <= run ? S_DIVI : S_IDLE;
          S_DIVI: st_reg <= div_done ? S_DIVD : S_DIVI;
          S_DIVD: st_reg <= div_done ? S_MATH : S_DIVD;
          S_MATH: st_reg <= S_UPD;
          S_UPD: st_reg <= S_IDLE;
          default: st_reg <= S_IDLE;
        endcase
      end
    end

    // operand capture and signed terms
    always_ff @(posedge clk) begin
      if (rst) begin
        e_reg <= '0;
        dpv_reg <= '0;
        pvprev_reg <= '0;
        inc_reg <= '0;
        d_reg <= '0;
        sum_reg <= '0;
      end else begin
        if (go && st_reg == S_IDLE) begin
          // rate taken from the process variable
          pvprev_reg <= pv;
          dpv_reg <= $signed({1'b0, pv}) - $signed({1'b0, pvprev_reg});
          e_reg <= e_now;
        end
        if (st_reg == S_DIVI && div_done) begin
          inc_reg <= e_reg[17] ? -$signed(quo) : $signed(quo);
        end
        if (st_reg == S_DIVD && div_done) begin
          d_reg <= dpv_reg[17] ? -$signed(quo) : $signed(quo);
        end
        if (st_reg == S_MATH) begin
          // stale integral ignored while ti is zero
          sum_reg <= 48'(e_reg)
            + ((c.ti == '0) ? 48'sh0 : integ_reg) - d_reg;
        end
      end
    end

    // gain product, scaled back to 16 fraction bits
    assign prod = 81'(sum_reg) * 81'($signed({1'b0, c.gain}));
    assign ylt0 = prod[80];
    assign ygt1 = !prod[80] && prod[80:GFRAC] > 66'(ONE);
    assign clip = ylt0 ? '0 : ygt1 ? ONE : prod[GFRAC +: NW];
    // saturating in the direction of the error
    assign wind = (ygt1 && e_reg > 0) || (ylt0 && e_reg < 0);

    // integrator
    always_ff @(posedge clk) begin
      if (rst) begin
        integ_reg <= '0;
      end else if (rst_act) begin
        integ_reg <= '0;
      end else if (st_reg == S_UPD && !wind && !c.manual) begin
        integ_reg <= sadd(integ_reg, inc_reg);
      end
    end

    // output; manual wins over reset, both over the loop
    always_ff @(posedge clk) begin
      if (rst) begin
        out_reg <= '0;
        wind_reg <= 1'b0;
        done_reg <= 1'b0;
      end else begin
        done_reg <= 1'b0;
        if (c.manual) begin
          out_reg <= c.man_val;
        end else if (rst_act) begin
          out_reg <= '0;
          wind_reg <= 1'b0;
        end else if (st_reg == S_UPD) begin
          out_reg <= clip;
          wind_reg <= wind;
          done_reg <= 1'b1;
        end
      end
    end

    assign out_arr[g] = out_reg;
    assign wind_arr[g] = wind_reg;
    assign rsta_arr[g] = rst_act;
    assign integ_arr[g] = integ_reg;
    assign ctrl_out[g] = out_reg;
    assign cycle_done[g] = done_reg;
  end
endmodule
`default_nettype wire

// File: dv/pidr_checker.sv
`timescale 1ns/1ns
`default_nettype none
module pidr_checker
  import pidr_pkg::*;
#(
  parameter int NSRC = 8,
  parameter int MS_CYCLES = MS_NS / CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [NSRC-1:0][NW-1:0] src_val,
  input wire logic [NINST-1:0][NW-1:0] ctrl_out,
  input wire logic [NINST-1:0] cycle_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // a request is taken while ack is low, answered by a single ack pulse
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_bus_answer: assert property (s_req |=> s_ans)
    else $error("ack missing or longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o)
    |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_ack_quiet: assert property (!wb_cyc_i |=> !wb_ack_o)
    else $error("ack after idle bus");
  a_write_rdzero: assert property (wb_ack_o && $past(wb_we_i)
    |-> wb_dat_o == 32'h0)
    else $error("read data not zero on write ack");
  a_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i)
    && $past(wb_adr_i) >= 8'h40 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_clip_range: assert property (ctrl_out[0] <= ONE
    && ctrl_out[1] <= ONE)
    else $error("output above one");
  // a loop pass takes far longer than eight clocks, so pulses never crowd
  a_done0_gap: assert property (cycle_done[0] |=> !cycle_done[0] [*8])
    else $error("cycle done 0 too close");
  a_done1_gap: assert property (cycle_done[1] |=> !cycle_done[1] [*8])
    else $error("cycle done 1 too close");
  a_reset_clear: assert property ($fell(rst) |-> ctrl_out == '0
    && cycle_done == '0 && !wb_ack_o)
    else $error("outputs not cleared by reset");
endmodule
bind pidr_top pidr_checker #(.NSRC(NSRC), .MS_CYCLES(MS_CYCLES))
  u_pidr_checker (
  .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .src_val(src_val), .ctrl_out(ctrl_out), .cycle_done(cycle_done));
`default_nettype wire

// File: dv/pidr_src_model.sv
`timescale 1ns/1ns
`default_nettype none
module pidr_src_model
  import pidr_pkg::*;
#(
  parameter int NSRC = 8
) (
  input wire logic clk,
  output logic [NSRC-1:0][NW-1:0] src_val
);
  // other blocks start from distinct levels so a wrong pick shows
  initial begin
    for (int i = 0; i < NSRC; i++) begin
      src_val[i] = NW'(17'h00100 * (i + 1));
    end
  end
  // source k feeds src_val[k-1]; changes land right after an edge
  // source numbering
  task put(input int k, input logic [NW-1:0] v);
    @(posedge clk);
    src_val[k-1] <= v;
  endtask
endmodule
`default_nettype wire

// File: dv/test_pid_regulator.sv
`timescale 1ns/1ns
`default_nettype none
module test_pid_regulator;
  import pidr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0][NW-1:0] src_val;
  logic [NINST-1:0][NW-1:0] ctrl_out;
  logic [NINST-1:0] cycle_done;
  logic [31:0] rd;
  logic [31:0] dflt [6] = '{32'h0, 32'h8000, 32'h8000, 32'h64, 32'ha, 32'h1};
  int fail_count = 0;
  int n_checks = 0;
  // 125 MHz
  always #4 clk = ~clk;
  pidr_top #(.NSRC(8), .MS_CYCLES(10)) u_pidr_top (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .src_val(src_val), .ctrl_out(ctrl_out), .cycle_done(cycle_done));
  pidr_src_model #(.NSRC(8)) u_pidr_src_model (.clk(clk), .src_val(src_val));
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one classic cycle; request held until ack is sampled high
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      summarize();
    end
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task rdc(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    check(rd, exp);
  endtask
  // waits for the loop result of regulator 0; bounded against a hang
  task wait_done(input int cnt);
    int n;
    repeat (cnt) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (cycle_done[0] !== 1'b1 && n < 400);
      if (n >= 400) begin
        fail_count++;
        summarize();
      end
    end
  endtask
  // overall limit in case a loop slips through
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // defaults of both regulators
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 6; i++) begin
        rdc(8'(r * 32 + i * 4), dflt[i]);
      end
    end
    wb(1'b1, 8'h40, 32'h1234);
    rdc(8'h40, 32'h0);
    // settings clamp to their limits
    wb(1'b1, 8'h08, 32'hffffffff);
    rdc(8'h08, GAIN_MAX);
    wb(1'b1, 8'h0c, 32'hffffffff);
    rdc(8'h0c, T_MAX);
    wb(1'b1, 8'h14, 32'h0);
    rdc(8'h14, DT_MIN);
    wb(1'b1, 8'h14, 32'hffffffff);
    rdc(8'h14, DT_MAX);
    wb(1'b1, 8'h14, 32'h1);
    // proportional only: ti and td zero
    wb(1'b1, 8'h0c, 32'h0);
    wb(1'b1, 8'h10, 32'h0);
    wb(1'b1, 8'h08, 32'h8000);
    u_pidr_src_model.put(1, 17'h06000);
    u_pidr_src_model.put(2, 17'h02000);
    u_pidr_src_model.put(3, 17'h00000);
    wb(1'b1, 8'h00, 32'h00032100);
    wait_done(2);
    check(32'(ctrl_out[0]), 32'h4000);
    check(32'(ctrl_out[1]), 32'h0);
    wb(1'b1, 8'h00, 32'h00032101);
    wait_done(2);
    check(32'(ctrl_out[0]), 32'h8000);
    wb(1'b1, 8'h00, 32'h00031200);
    wait_done(2);
    check(32'(ctrl_out[0]), 32'h0);
    // gain 8 drives the output past one while error stays positive
    wb(1'b1, 8'h00, 32'h00032100);
    wb(1'b1, 8'h08, 32'h40000);
    wb(1'b1, 8'h0c, 32'h1);
    wait_done(2);
    check(32'(ctrl_out[0]), 32'h10000);
    rdc(8'h1c, 32'h0);
    rdc(8'h18, 32'h01010000);
    // reset input at exactly one half
    u_pidr_src_model.put(3, HALF);
    repeat (30) @(posedge clk);
    check(32'(ctrl_out[0]), 32'h0);
    wb(1'b0, 8'h18, 32'h0);
    check(rd & 32'h02000000, 32'h02000000);
    // just below one half, inverted, still resets
    u_pidr_src_model.put(3, 17'h07fff);
    wb(1'b1, 8'h08, 32'h8000);
    wb(1'b1, 8'h00, 32'h00032104);
    u_pidr_src_model.put(1, 17'h03000);
    repeat (250) @(posedge clk);
    check(32'(ctrl_out[0]), 32'h0);
    rdc(8'h1c, 32'h0);
    // released: integrator grows by e*dt/ti each pass
    wb(1'b1, 8'h00, 32'h00032100);
    wait_done(1);
    check(32'(ctrl_out[0]), 32'h1000);
    rdc(8'h1c, 32'h1000);
    wait_done(1);
    check(32'(ctrl_out[0]), 32'h2000);
    // manual override, then the second regulator alone
    wb(1'b1, 8'h04, 32'h4000);
    wb(1'b1, 8'h00, 32'h00032108);
    repeat (5) @(posedge clk);
    check(32'(ctrl_out[0]), 32'h4000);
    wb(1'b1, 8'h04, 32'h1ffff);
    rdc(8'h04, 32'h10000);
    wb(1'b1, 8'h24, 32'h2000);
    wb(1'b1, 8'h20, 32'h8);
    repeat (5) @(posedge clk);
    check(32'(ctrl_out[1]), 32'h2000);
    check(32'(ctrl_out[0]), 32'h10000);
    // proportional and derivative; the stale integral must not count while ti is 0
    wb(1'b1, 8'h0c, 32'h0);
    wb(1'b1, 8'h10, 32'h1);
    wb(1'b1, 8'h00, 32'h00032100);
    wait_done(2);
    check(32'(ctrl_out[0]), 32'h1000);
    // step lands between passes, so the next pass sees the whole rate
    u_pidr_src_model.put(2, 17'h02800);
    wait_done(1);
    check(32'(ctrl_out[0]), 32'h0);
    wait_done(1);
    check(32'(ctrl_out[0]), 32'h800);
    summarize();
  end
endmodule
`default_nettype wire
